// [dv/cell_assertions.sv]
// port checker for the logic cell
`timescale 1ns/100ps
module cell_assertions (
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  input wire cell_pkg::reg_req_t    bus_req,
  input wire logic [7:0]            rdata,
  input wire logic                  sysclk_is_fast_osc,
  input wire logic                  sleep_req,
  input wire logic                  cell_out_wire,
  input wire logic                  cell_irq_flag,
  input wire logic                  output_mirror,
  input wire cell_pkg::sleep_hint_t sleep_hint
);
  import cell_pkg::*;
  logic [7:0] ctrl_q;
  logic       clr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // shadow of the control byte, so no view inside the cell is needed
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= 8'h00;
    end else if (bus_req.wr && bus_req.addr == 4'h0) begin
      ctrl_q <= bus_req.wdata & 8'h9F;
    end
  end
  assign clr = bus_req.wr && bus_req.addr == 4'hA && !bus_req.wdata[0];
  sequence s_rd_ctrl;
    bus_req.rd && bus_req.addr == 4'h0;
  endsequence
  sequence s_irq_edge;
    ($past(ctrl_q[4]) && $rose(cell_out_wire)) || ($past(ctrl_q[3]) && $fell(cell_out_wire));
  endsequence
  ////////////////////////////////////////////////////////////
  a_ctrl_read: assert property (s_rd_ctrl |=>
    rdata == {ctrl_q[7], 1'b0, $past(cell_out_wire), ctrl_q[4:0]}) else $error("control read");
  a_sel_upper: assert property (bus_req.rd && bus_req.addr inside {[4'h2:4'h5]}
    |=> rdata[7:5] == 3'b000) else $error("select upper bits");
  a_off_zero: assert property (!ctrl_q[7] |=> !cell_out_wire)
    else $error("output while off");
  a_rise_flag: assert property ($past(ctrl_q[4]) && $rose(cell_out_wire) |-> cell_irq_flag)
    else $error("rise missed");
  a_fall_flag: assert property ($past(ctrl_q[3]) && $fell(cell_out_wire) |-> cell_irq_flag)
    else $error("fall missed");
  a_flag_cause: assert property ($rose(cell_irq_flag) |-> s_irq_edge)
    else $error("flag without edge");
  a_flag_clear: assert property (clr |=> !cell_irq_flag || $changed(cell_out_wire))
    else $error("flag not cleared");
  a_flag_hold: assert property ($fell(cell_irq_flag) |-> $past(clr))
    else $error("flag dropped");
  a_mirror_copy: assert property (output_mirror == cell_out_wire)
    else $error("mirror differs");
  a_osc_keep: assert property (sleep_hint.fast_osc_keep_on |-> ctrl_q[7])
    else $error("oscillator kept while off");
  a_idle_hint: assert property (sleep_hint.cpu_only_idle ==
    (sleep_hint.fast_osc_keep_on && sysclk_is_fast_osc && sleep_req)) else $error("idle hint");
endmodule

// [dv/configurable_logic_cell_tb.sv]
// self-checking bench for the logic cell
`timescale 1ns/100ps
module configurable_logic_cell_tb;
  import cell_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  reg_req_t    bus_req = '0;
  logic [31:0] level = '0;
  logic        osc_run = 1'b0;
  logic        sysclk_is_fast_osc = 1'b0;
  logic        sleep_req = 1'b0;
  logic [7:0]  rdata;
  logic [31:0] sources;
  logic        cell_out_wire;
  logic        cell_irq_flag;
  logic        output_mirror;
  sleep_hint_t sleep_hint;
  int          n_errors = 0;
  int          checks = 0;
  always #50 clk_sys = ~clk_sys;
  periph_sources i_src (.clk_sys(clk_sys), .osc_run(osc_run), .level(level), .sources(sources));
  configurable_logic_cell i_dut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
    .rdata(rdata), .sources(sources), .sysclk_is_fast_osc(sysclk_is_fast_osc),
    .sleep_req(sleep_req), .cell_out_wire(cell_out_wire), .cell_irq_flag(cell_irq_flag),
    .output_mirror(output_mirror), .sleep_hint(sleep_hint));
  ////////////////////////////////////////////////////////////
  task automatic chk(string w, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask
  task automatic chk1(string w, logic e, logic g);
    chk(w, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m);
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 chk("register read", e & m, rdata & m);
  endtask
  // five edges cover the two sync flops and the output register
  task automatic put(logic [31:0] v);
    @(posedge clk_sys);
    level <= v;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(4'h0, 8'h00, 8'hFF);
    wr(4'h2, 8'hFF);
    wr(4'h0, 8'h1F);
    rd(4'h2, 8'h1F, 8'hFF);
    rd(4'h0, 8'h1F, 8'hFF);
    wr(4'hC, 8'h55);
    rd(4'hC, 8'h00, 8'hFF);
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h8F, 8'hFF);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(4'h0, 8'h00, 8'hFF);
    rd(4'h2, 8'h1F, 8'hFF);
    for (int a = 3; a < 10; a++) wr(a[3:0], {7'h00, a == 3});
    rd(4'h3, 8'h01, 8'hFF);
    rd(4'h7, 8'h00, 8'hFF);
    $display("register test done");
  endtask
  // each entry: control, polarity, gate 1 enables, {invert, select}
  task automatic t_comb;
    logic [31:0] tc [6] = '{32'h820E0200, 32'h828E0291, 32'h820F029F,
                            32'h820E0183, 32'h80060205, 32'h8104028A};
    logic e;
    foreach (tc[i]) begin
      wr(4'h1, tc[i][23:16]);
      wr(4'h6, tc[i][15:8]);
      wr(4'h2, tc[i][7:0] & 8'h1F);
      wr(4'h0, tc[i][31:24]);
      for (int s = 0; s < 2; s++) begin
        e = s[0] ^ tc[i][7];
        put({31'h0, s[0]} << tc[i][4:0]);
        chk1("cell output", e, cell_out_wire);
        chk1("mirror", e, output_mirror);
        rd(4'hB, {7'h00, e}, 8'hFF);
        rd(4'h0, tc[i][31:24] | {2'b00, e, 5'h00}, 8'hFF);
      end
    end
    $display("combinational test done");
  endtask
  // each entry: control, source level, expected output
  task automatic t_seq;
    logic [15:0] sq [14] = '{16'h8420, 16'h8431, 16'h8411, 16'h0410, 16'h8731, 16'h8721,
      16'h8701, 16'h8710, 16'h0300, 16'h8311, 16'h8301, 16'h0600, 16'h8600, 16'h8631};
    // gate 3 takes data 4 as reset, gate 4 takes data 3 as set, k or second data
    logic [15:0] sr [11] = '{16'h0500, 16'h8571, 16'h85A0, 16'h8530, 16'h8441, 16'h84C0,
      16'h8741, 16'h8601, 16'h8650, 16'h8321, 16'h8380};
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h7, 8'h08);
    foreach (sq[i]) begin
      wr(4'h0, sq[i][15:8]);
      put({28'h0, sq[i][7:4]});
      chk1("cell output", sq[i][0], cell_out_wire);
    end
    wr(4'h4, 8'h02);
    wr(4'h5, 8'h03);
    wr(4'h8, 8'h80);
    wr(4'h9, 8'h20);
    foreach (sr[i]) begin
      wr(4'h0, sr[i][15:8]);
      put({28'h0, sr[i][7:4]});
      chk1("cell output", sr[i][0], cell_out_wire);
    end
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h00);
    $display("sequential test done");
  endtask
  task automatic t_irq;
    wr(4'h1, 8'h0E);
    wr(4'h7, 8'h00);
    wr(4'h0, 8'h92);
    put(32'h0);
    wr(4'hA, 8'h00);
    put(32'h1);
    chk1("irq flag", 1'b1, cell_irq_flag);
    rd(4'hA, 8'h01, 8'h01);
    wr(4'hA, 8'h00);
    chk1("irq flag", 1'b0, cell_irq_flag);
    put(32'h0);
    chk1("irq flag", 1'b0, cell_irq_flag);
    wr(4'h0, 8'h8A);
    put(32'h1);
    chk1("irq flag", 1'b0, cell_irq_flag);
    put(32'h0);
    chk1("irq flag", 1'b1, cell_irq_flag);
    wr(4'hA, 8'h00);
    put(32'h1);
    // the clear lands on the very edge at which the output falls
    @(posedge clk_sys);
    level <= 32'h0;
    repeat (2) @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, 4'hA, 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 chk1("irq flag", 1'b1, cell_irq_flag);
    $display("interrupt test done");
  endtask
  task automatic t_sleep;
    wr(4'h5, 8'h1E);
    @(posedge clk_sys);
    osc_run <= 1'b1;
    sysclk_is_fast_osc <= 1'b1;
    sleep_req <= 1'b1;
    wr(4'h0, 8'h82);
    chk1("osc hint", 1'b1, sleep_hint.fast_osc_keep_on);
    chk1("idle hint", 1'b1, sleep_hint.cpu_only_idle);
    put(32'h1);
    chk1("cell output", 1'b1, cell_out_wire);
    wr(4'h0, 8'h02);
    chk1("osc hint", 1'b0, sleep_hint.fast_osc_keep_on);
    chk1("idle hint", 1'b0, sleep_hint.cpu_only_idle);
    $display("sleep test done");
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs;
    t_comb;
    t_seq;
    t_irq;
    t_sleep;
    complete_run;
  end
endmodule
bind configurable_logic_cell cell_assertions i_chk (.clk_sys(clk_sys), .rstn(rstn),
  .bus_req(bus_req), .rdata(rdata), .sysclk_is_fast_osc(sysclk_is_fast_osc),
  .sleep_req(sleep_req), .cell_out_wire(cell_out_wire), .cell_irq_flag(cell_irq_flag),
  .output_mirror(output_mirror), .sleep_hint(sleep_hint));

// [dv/periph_sources.sv]
// far-side model: peripheral levels plus a fast oscillator on code 30
`timescale 1ns/100ps
module periph_sources (
  input  wire logic        clk_sys,
  input  wire logic        osc_run,
  input  wire logic [31:0] level,
  output logic [31:0]      sources
);
  logic osc_q = 1'b0;
  // stands still unless asked to run, as a stopped oscillator would
  always @(posedge clk_sys) begin
    if (osc_run) begin
      osc_q <= ~osc_q;
    end
  end
  assign sources = {level[31], osc_q, level[29:0]};
endmodule

// [hdl/cell_pkg.sv]
// types shared by the logic cell and its bench
package cell_pkg;

  // one register access from software
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // power hints toward the clock controller
  typedef struct packed {
    logic fast_osc_keep_on;
    logic cpu_only_idle;
  } sleep_hint_t;

  typedef enum logic [2:0] {
    FN_AND_OR  = 3'b000,
    FN_OR_XOR  = 3'b001,
    FN_AND4    = 3'b010,
    FN_SR      = 3'b011,
    FN_DFF_SR  = 3'b100,
    FN_DFF2_R  = 3'b101,
    FN_JK_R    = 3'b110,
    FN_LATCH   = 3'b111
  } func_mode_t;

endpackage

// [hdl/cell_regs.svh]
// register indices, field positions and reset values of the logic cell
`ifndef CELL_REGS_SVH
`define CELL_REGS_SVH

`define CELL_CONTROL_IDX   4'h0
`define CELL_POLARITY_IDX  4'h1
`define DATA1_SELECT_IDX   4'h2
`define DATA2_SELECT_IDX   4'h3
`define DATA3_SELECT_IDX   4'h4
`define DATA4_SELECT_IDX   4'h5
`define GATE1_ENABLES_IDX  4'h6
`define GATE2_ENABLES_IDX  4'h7
`define GATE3_ENABLES_IDX  4'h8
`define GATE4_ENABLES_IDX  4'h9
`define CELL_STATUS_IDX    4'hA
`define OUTPUT_MIRROR_IDX  4'hB

`define CELL_ON_BIT        7
`define RESULT_BIT         5
`define RISE_ALLOW_BIT     4
`define FALL_ALLOW_BIT     3
`define FINAL_INVERT_BIT   7
`define CELL_CONTROL_RST   8'h00
`define CONTROL_WR_MASK    8'h9F
`define POLARITY_WR_MASK   8'h8F
`define IRQ_FLAG_BIT       0
`define FAST_OSC_CODE      5'h1E

`endif

// [hdl/configurable_logic_cell.sv]
// one configurable logic cell with its byte register file
`timescale 1ns/100ps
`include "cell_regs.svh"

module configurable_logic_cell #(
  parameter int N_SRC = 32,
  parameter int SEL_W = 5
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire cell_pkg::reg_req_t   bus_req,
  output logic [7:0]                rdata,
  input  wire logic [N_SRC-1:0]     sources,
  input  wire logic                 sysclk_is_fast_osc,
  input  wire logic                 sleep_req,
  output logic                      cell_out_wire,
  output logic                      cell_irq_flag,
  output logic                      output_mirror,
  output cell_pkg::sleep_hint_t     sleep_hint
);
  import cell_pkg::*;

  // the multiplexer codes must cover the sources exactly and fit a byte register
  if (N_SRC != (1 << SEL_W) || SEL_W > 8) begin : g_bad_width
    $error("source count must equal two to the select width, at most eight bits");
  end

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [N_SRC-1:0]            sync1;
    logic [N_SRC-1:0]            sync2;
    logic [7:0]                  ctrl;
    logic [7:0]                  pol;
    logic [3:0][SEL_W-1:0]       sel;
    logic [3:0][7:0]             gls;
    logic                        gclk;
    logic                        q;
    logic                        out;
    logic                        flag;
    logic [7:0]                  rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  //////////////////////////////////////////////////////////////////////////
  // gate evaluation

  // and of the enabled terms; an empty gate is low before its polarity bit
  function automatic logic gate_eval(input logic [7:0] en, input logic [3:0] d);
    logic r;
    r = |en;
    for (int i = 0; i < 4; i++) begin
      if (en[2*i+1]) begin
        r = r & d[i];
      end
      if (en[2*i]) begin
        r = r & ~d[i];
      end
    end
    return r;
  endfunction

  logic [3:0]  dsel;
  logic [3:0]  g;
  logic        cell_on;
  logic        clk_rise;
  logic        set_in;
  logic        rst_in;
  logic        func;
  logic        q_next;
  logic        out_next;
  logic        rise;
  logic        fall;
  logic        clr_flag;
  logic        fast_sel;
  func_mode_t  mode;

  assign cell_on = s_q.ctrl[`CELL_ON_BIT];
  assign mode    = func_mode_t'(s_q.ctrl[2:0]);

  //////////////////////////////////////////////////////////////////////////
  // data path and registers

  always_comb begin
    s_d = s_q;
    // sources come from other domains and pins, so two stages first
    s_d.sync1 = sources;
    s_d.sync2 = s_q.sync1;

    // every gate sees all four picked inputs, so pick them all before any gate
    for (int k = 0; k < 4; k++) begin
      dsel[k] = s_q.sync2[s_q.sel[k]];
    end
    for (int k = 0; k < 4; k++) begin
      g[k] = gate_eval(s_q.gls[k], dsel) ^ s_q.pol[k];
    end

    // sequential roles: g0 clock or enable, g1 data, g2 reset, g3 set
    clk_rise = g[0] & ~s_q.gclk;
    rst_in   = g[2];
    set_in   = g[3];
    q_next   = s_q.q;
    func     = 1'b0;
    case (mode)
      FN_AND_OR: begin
        func = (g[0] & g[1]) | (g[2] & g[3]);
      end
      FN_OR_XOR: begin
        func = (g[0] | g[1]) ^ (g[2] | g[3]);
      end
      FN_AND4: begin
        func = &g;
      end
      FN_SR: begin
        // set has priority when both are high
        if (g[0] | g[1]) begin
          q_next = 1'b1;
        end else if (g[2] | g[3]) begin
          q_next = 1'b0;
        end
        func = q_next;
      end
      FN_DFF_SR: begin
        if (rst_in) begin
          q_next = 1'b0;
        end else if (set_in) begin
          q_next = 1'b1;
        end else if (clk_rise) begin
          q_next = g[1];
        end
        func = q_next;
      end
      FN_DFF2_R: begin
        if (rst_in) begin
          q_next = 1'b0;
        end else if (clk_rise) begin
          q_next = g[1] & g[3];
        end
        func = q_next;
      end
      FN_JK_R: begin
        // j on gate 2, k on gate 4
        if (rst_in) begin
          q_next = 1'b0;
        end else if (clk_rise) begin
          q_next = (g[1] & ~s_q.q) | (~g[3] & s_q.q);
        end
        func = q_next;
      end
      FN_LATCH: begin
        if (rst_in) begin
          q_next = 1'b0;
        end else if (set_in) begin
          q_next = 1'b1;
        end else if (g[0]) begin
          q_next = g[1];
        end
        func = q_next;
      end
      default: begin
        func = 1'b0;
      end
    endcase

    // a disabled cell drops its stored bit so it restarts cleanly
    s_d.q    = cell_on ? q_next : 1'b0;
    s_d.gclk = g[0];

    out_next = cell_on & (func ^ s_q.pol[`FINAL_INVERT_BIT]);
    s_d.out  = out_next;

    // edges against the previous output, so each one counts once
    rise = out_next & ~s_q.out;
    fall = ~out_next & s_q.out;

    clr_flag = bus_req.wr && (bus_req.addr == `CELL_STATUS_IDX)
               && !bus_req.wdata[`IRQ_FLAG_BIT];

    // a new edge beats a clear in the same cycle
    if ((rise && s_q.ctrl[`RISE_ALLOW_BIT])
        || (fall && s_q.ctrl[`FALL_ALLOW_BIT])) begin
      s_d.flag = 1'b1;
    end else if (clr_flag) begin
      s_d.flag = 1'b0;
    end

    // register writes; unmapped indices are ignored
    if (bus_req.wr) begin
      case (bus_req.addr)
        `CELL_CONTROL_IDX: begin
          s_d.ctrl = bus_req.wdata & `CONTROL_WR_MASK;
        end
        `CELL_POLARITY_IDX: begin
          s_d.pol = bus_req.wdata & `POLARITY_WR_MASK;
        end
        `DATA1_SELECT_IDX: begin
          s_d.sel[0] = bus_req.wdata[SEL_W-1:0];
        end
        `DATA2_SELECT_IDX: begin
          s_d.sel[1] = bus_req.wdata[SEL_W-1:0];
        end
        `DATA3_SELECT_IDX: begin
          s_d.sel[2] = bus_req.wdata[SEL_W-1:0];
        end
        `DATA4_SELECT_IDX: begin
          s_d.sel[3] = bus_req.wdata[SEL_W-1:0];
        end
        `GATE1_ENABLES_IDX: begin
          s_d.gls[0] = bus_req.wdata;
        end
        `GATE2_ENABLES_IDX: begin
          s_d.gls[1] = bus_req.wdata;
        end
        `GATE3_ENABLES_IDX: begin
          s_d.gls[2] = bus_req.wdata;
        end
        `GATE4_ENABLES_IDX: begin
          s_d.gls[3] = bus_req.wdata;
        end
        default: begin
          s_d.gls = s_q.gls;
        end
      endcase
    end

    // read data stand one cycle after the strobe, zero otherwise
    s_d.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `CELL_CONTROL_IDX: begin
          s_d.rdata = s_q.ctrl;
          s_d.rdata[`RESULT_BIT] = s_q.out;
        end
        `CELL_POLARITY_IDX: begin
          s_d.rdata = s_q.pol;
        end
        `DATA1_SELECT_IDX: begin
          s_d.rdata = 8'(s_q.sel[0]);
        end
        `DATA2_SELECT_IDX: begin
          s_d.rdata = 8'(s_q.sel[1]);
        end
        `DATA3_SELECT_IDX: begin
          s_d.rdata = 8'(s_q.sel[2]);
        end
        `DATA4_SELECT_IDX: begin
          s_d.rdata = 8'(s_q.sel[3]);
        end
        `GATE1_ENABLES_IDX: begin
          s_d.rdata = s_q.gls[0];
        end
        `GATE2_ENABLES_IDX: begin
          s_d.rdata = s_q.gls[1];
        end
        `GATE3_ENABLES_IDX: begin
          s_d.rdata = s_q.gls[2];
        end
        `GATE4_ENABLES_IDX: begin
          s_d.rdata = s_q.gls[3];
        end
        `CELL_STATUS_IDX: begin
          s_d.rdata = {7'h00, s_q.flag};
        end
        `OUTPUT_MIRROR_IDX: begin
          s_d.rdata = {7'h00, s_q.out};
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // only control state resets; configuration has no reset and starts unknown
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q.ctrl  <= `CELL_CONTROL_RST;
      s_q.sync1 <= '0;
      s_q.sync2 <= '0;
      s_q.gclk  <= 1'b0;
      s_q.q     <= 1'b0;
      s_q.out   <= 1'b0;
      s_q.flag  <= 1'b0;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs and sleep hints

  always_comb begin
    fast_sel = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (s_q.sel[k] == `FAST_OSC_CODE) begin
        fast_sel = 1'b1;
      end
    end
  end

  // the cell never gates its own clock; keeping it alive in sleep is the hint's job
  // the hint word has one driver, so no tool sees two assignments to one variable
  assign sleep_hint = '{
    fast_osc_keep_on: cell_on & fast_sel,
    cpu_only_idle:    cell_on & fast_sel & sysclk_is_fast_osc & sleep_req
  };

  assign cell_out_wire = s_q.out;
  assign cell_irq_flag = s_q.flag;
  assign output_mirror = s_q.out;
  assign rdata         = s_q.rdata;

endmodule
